// File: logic/dps_cfg.svh
// dps_cfg.svh: constants for the dancer speed trim block
// assumes: included by the package and by the design modules
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

// ------------------------------------------------------------------
// action selection codes
// ------------------------------------------------------------------
`define DPS_ACT_OFF        8'h00
`define DPS_ACT_REV_FIXED  8'h28
`define DPS_ACT_FWD_FIXED  8'h29
`define DPS_ACT_REV_RATIO  8'h2a
`define DPS_ACT_FWD_RATIO  8'h2b

// ------------------------------------------------------------------
// terminal function codes
// ------------------------------------------------------------------
`define DPS_IN_FUNC_ENABLE 8'h0e
`define DPS_OUT_FUNC_LOWER 8'h0e
`define DPS_OUT_FUNC_UPPER 8'h0f
`define DPS_OUT_FUNC_DIR   8'h10
`define DPS_OUT_FUNC_PID   8'h2f
`define DPS_OUT_NEG_BASE   8'h64

// ------------------------------------------------------------------
// percent values, in tenths of a percent, and the parameter-not-set code
// ------------------------------------------------------------------
`define DPS_PARAM_NONE     16'h270f
`define DPS_PCT_HALF       16'h01f4
`define DPS_PCT_FULL       16'h03e8

// ------------------------------------------------------------------
// measured input range codes and converter scaling
// ------------------------------------------------------------------
`define DPS_RANGE_4_20MA   2'h0
`define DPS_RANGE_0_5V     2'h1
`define DPS_RANGE_0_10V    2'h2
`define DPS_ADC_FULL       12'hfff
`define DPS_ADC_4MA        12'h333
`define DPS_ADC_5V         12'h7ff

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define DPS_RST_SPEED      16'h0000
`define DPS_RST_PCT        16'h0000

`endif

// File: logic/dps_dancer_trim.sv
// dps_dancer_trim.sv: dancer-roller control selection and speed trim
// assumes: one clock, sync active-low reset; PID correction on the same
// clock from an outside unit; terminal levels and converter code from pins
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_dancer_trim
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  actionSelectParam,
    input  wire logic [7:0]  inputFunctionSelect0,
    input  wire logic [7:0]  inputFunctionSelect1,
    input  wire logic [7:0]  inputFunctionSelect2,
    input  wire logic [7:0]  inputFunctionSelect3,
    input  wire logic [7:0]  inputFunctionSelect4,
    input  wire logic [4:0]  inputTerminals,
    input  wire logic [7:0]  outputFunctionSelectA,
    input  wire logic [7:0]  outputFunctionSelectB,
    input  wire logic [7:0]  outputFunctionSelectC,
    input  wire logic [15:0] setPointParam,
    input  wire logic [15:0] upperLimitParam,
    input  wire logic [15:0] lowerLimitParam,
    input  wire logic [15:0] thermistorLevelParam,
    input  wire logic [1:0]  inputRangeSelect,
    input  wire logic [11:0] measuredAdc,
    input  wire logic [15:0] analogGainFrequency,
    input  wire logic [15:0] analogBiasFrequency,
    input  wire logic [15:0] mainSpeedCmd,
    input  wire dps_pkg::dps_src_t mainSpeedSource,
    input  wire logic [15:0] outputFrequency,
    input  wire logic        running,
    input  wire logic        reverseDir,
    input  wire logic signed [11:0] pidCorrection,
    output logic [15:0]      speedCommand,
    output logic [15:0]      setPointPct,
    output logic [15:0]      setPointFreq,
    output logic [15:0]      measuredValuePct,
    output logic             pidReverseAction,
    output logic             mainSpeedRejected,
    output logic [2:0]       outputTerminals
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0]  termMeta_r;
    logic [4:0]  termSync_r;
    logic [11:0] adcMeta_r;
    logic [11:0] adcSync_r;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            termMeta_r <= 5'h00;
            termSync_r <= 5'h00;
            adcMeta_r  <= 12'h000;
            adcSync_r  <= 12'h000;
        end
        else
        begin
            termMeta_r <= inputTerminals;
            termSync_r <= termMeta_r;
            adcMeta_r  <= measuredAdc;
            adcSync_r  <= adcMeta_r;
        end
    end

    dps_measured_scaler i_dps_measured_scaler
    (
        .clk              (clk),
        .rst_b            (rst_b),
        .inputRangeSelect (inputRangeSelect),
        .adcCode          (adcSync_r),
        .measuredPct      (measuredValuePct)
    );

    // ------------------------------------------------------------------
    // enable conditions
    // ------------------------------------------------------------------
    logic [7:0] inSel [5];
    logic [4:0] enAssigned;
    logic       enableAssigned;
    logic       enableLevel;
    logic       actionValid;
    logic       dancerWanted;

    assign inSel[0] = inputFunctionSelect0;
    assign inSel[1] = inputFunctionSelect1;
    assign inSel[2] = inputFunctionSelect2;
    assign inSel[3] = inputFunctionSelect3;
    assign inSel[4] = inputFunctionSelect4;

    for (genvar gi = 0; gi < 5; gi++)
    begin : g_in
        assign enAssigned[gi] = (inSel[gi] == `DPS_IN_FUNC_ENABLE);
    end

    always_comb
    begin
        enableAssigned = |enAssigned;
        enableLevel    = |(enAssigned & termSync_r);
        actionValid    = (actionSelectParam >= `DPS_ACT_REV_FIXED) &&
                         (actionSelectParam <= `DPS_ACT_FWD_RATIO);
        // without an enable input the action value alone decides
        dancerWanted   = actionValid &&
                         (!enableAssigned || enableLevel);
    end

    // ------------------------------------------------------------------
    // dancer state and main speed base
    // ------------------------------------------------------------------
    dps_pkg::dps_state_t state_r;
    dps_pkg::dps_state_t state_nxt;
    logic [15:0]         baseSpeed_r;
    logic [15:0]         baseSpeed_nxt;
    logic                baseHeld_r;
    logic                baseHeld_nxt;
    logic                srcOk;

    always_comb
    begin
        srcOk = (mainSpeedSource != dps_pkg::DPS_SRC_TERM4) &&
                !((mainSpeedSource == dps_pkg::DPS_SRC_TERM2) &&
                  (thermistorLevelParam != `DPS_PARAM_NONE));
    end

    always_comb
    begin
        state_nxt     = state_r;
        baseSpeed_nxt = srcOk ? mainSpeedCmd : `DPS_RST_SPEED;
        baseHeld_nxt  = 1'b0;
        unique case (state_r)
            dps_pkg::DPS_ST_NORMAL:
            begin
                if (dancerWanted)
                begin
                    state_nxt = dps_pkg::DPS_ST_DANCER;
                    if (running)
                    begin
                        // switch in without a speed step
                        baseSpeed_nxt = outputFrequency;
                        baseHeld_nxt  = 1'b1;
                    end
                end
            end
            dps_pkg::DPS_ST_DANCER:
            begin
                if (!dancerWanted)
                begin
                    state_nxt = dps_pkg::DPS_ST_NORMAL;
                end
                else if (baseHeld_r)
                begin
                    baseSpeed_nxt = baseSpeed_r;
                    baseHeld_nxt  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r     <= dps_pkg::DPS_ST_NORMAL;
            baseSpeed_r <= `DPS_RST_SPEED;
            baseHeld_r  <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            baseSpeed_r <= baseSpeed_nxt;
            baseHeld_r  <= baseHeld_nxt;
        end
    end

    // ------------------------------------------------------------------
    // set point and speed trim arithmetic
    // ------------------------------------------------------------------
    logic               dancerOn;
    logic               ratioMode;
    logic [15:0]        spPct;
    logic [15:0]        spanFreq;
    logic [31:0]        spFreqWide;
    logic signed [31:0] fixedAdd;
    logic signed [47:0] ratioWide;
    logic signed [31:0] trimAdd;
    logic signed [31:0] sum;
    logic [15:0]        speed_nxt;
    logic [15:0]        speed_r;
    logic [15:0]        spPct_r;
    logic [15:0]        spFreq_r;
    logic               revAct_r;
    logic               revAct_nxt;
    logic               reject_r;

    always_comb
    begin
        dancerOn   = (state_r == dps_pkg::DPS_ST_DANCER);
        ratioMode  = actionSelectParam[1];
        revAct_nxt = !actionSelectParam[0];
        spPct      = (setPointParam == `DPS_PARAM_NONE) ? `DPS_PCT_HALF
                     : setPointParam;
        // calibrated gain and bias percentages are ignored here
        spanFreq   = (analogGainFrequency > analogBiasFrequency) ?
                     analogGainFrequency - analogBiasFrequency
                     : 16'h0000;
        spFreqWide = {16'h0000, analogBiasFrequency} +
                     ({16'h0000, spPct} * {16'h0000, spanFreq})
                     / {16'h0000, `DPS_PCT_FULL};
        fixedAdd   = ($signed({{20{pidCorrection[11]}}, pidCorrection}) *
                      $signed({16'h0000, spanFreq}))
                     / $signed({16'h0000, `DPS_PCT_FULL});
        ratioWide  = (analogGainFrequency == 16'h0000) ? 48'sh0
                     : ($signed({{16{fixedAdd[31]}}, fixedAdd}) *
                        $signed({32'h00000000, baseSpeed_r}))
                       / $signed({32'h00000000, analogGainFrequency});
        trimAdd    = !dancerOn ? 32'sh0
                     : ratioMode ? $signed(ratioWide[31:0])
                     : fixedAdd;
        sum = $signed({16'h0000, baseSpeed_r}) + trimAdd;
        speed_nxt  = (sum < 32'sh0) ? 16'h0000
                     : (sum > 32'sh0000ffff) ? 16'hffff : sum[15:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            speed_r  <= `DPS_RST_SPEED;
            spPct_r  <= `DPS_RST_PCT;
            spFreq_r <= `DPS_RST_SPEED;
            revAct_r <= 1'b0;
            reject_r <= 1'b0;
        end
        else
        begin
            speed_r  <= speed_nxt;
            spPct_r  <= spPct;
            spFreq_r <= (spFreqWide > 32'h0000ffff) ? 16'hffff
                        : spFreqWide[15:0];
            revAct_r <= revAct_nxt;
            reject_r <= !srcOk;
        end
    end

    // ------------------------------------------------------------------
    // status flags and output terminals
    // ------------------------------------------------------------------
    logic       upperFlag;
    logic       lowerFlag;
    logic       fwdFlag;
    logic       pidFlag;
    logic [7:0] outSel [3];
    logic [2:0] term_nxt;
    logic [2:0] term_r;

    always_comb
    begin
        upperFlag = actionValid && (upperLimitParam != `DPS_PARAM_NONE) &&
                    (measuredValuePct > upperLimitParam);
        lowerFlag = actionValid && (lowerLimitParam != `DPS_PARAM_NONE) &&
                    (measuredValuePct < lowerLimitParam);
        fwdFlag   = running && !reverseDir;
        pidFlag   = dancerOn;
    end

    assign outSel[0] = outputFunctionSelectA;
    assign outSel[1] = outputFunctionSelectB;
    assign outSel[2] = outputFunctionSelectC;

    for (genvar go = 0; go < 3; go++)
    begin : g_out
        logic       neg;
        logic [7:0] func;
        logic       level;
        always_comb
        begin
            neg  = (outSel[go] >= `DPS_OUT_NEG_BASE);
            func = neg ? outSel[go] - `DPS_OUT_NEG_BASE : outSel[go];
            unique case (func)
                `DPS_OUT_FUNC_UPPER: level = upperFlag;
                `DPS_OUT_FUNC_LOWER: level = lowerFlag;
                `DPS_OUT_FUNC_DIR:   level = fwdFlag;
                `DPS_OUT_FUNC_PID:   level = pidFlag;
                default:             level = 1'b0;
            endcase
            term_nxt[go] = level ^ neg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            term_r <= 3'h0;
        end
        else
        begin
            term_r <= term_nxt;
        end
    end

    assign speedCommand      = speed_r;
    assign setPointPct       = spPct_r;
    assign setPointFreq      = spFreq_r;
    assign pidReverseAction  = revAct_r;
    assign mainSpeedRejected = reject_r;
    assign outputTerminals   = term_r;

endmodule

`default_nettype wire

// File: logic/dps_measured_scaler.sv
// dps_measured_scaler.sv: converts the synchronised measured-value
// converter code into 0 to 100 percent (tenths) by the range selector
// assumes: code already passed two flip-flops; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_measured_scaler
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  inputRangeSelect,
    input  wire logic [11:0] adcCode,
    output logic      [15:0] measuredPct
);

    logic [15:0] measuredPct_r;
    logic [15:0] measuredPct_nxt;
    logic [11:0] offset;
    logic [11:0] span;
    logic [11:0] above;
    logic [31:0] scaled;

    // ------------------------------------------------------------------
    // range mapping
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (inputRangeSelect)
            `DPS_RANGE_0_5V:
            begin
                offset = 12'h000;
                span   = `DPS_ADC_5V;
            end
            `DPS_RANGE_0_10V:
            begin
                offset = 12'h000;
                span   = `DPS_ADC_FULL;
            end
            default:
            begin
                offset = `DPS_ADC_4MA;
                span   = `DPS_ADC_FULL - `DPS_ADC_4MA;
            end
        endcase
        above  = (adcCode > offset) ? adcCode - offset : 12'h000;
        scaled = ({20'h00000, above} * {16'h0000, `DPS_PCT_FULL})
                 / {20'h00000, span};
        if (scaled > {16'h0000, `DPS_PCT_FULL})
        begin
            measuredPct_nxt = `DPS_PCT_FULL;
        end
        else
        begin
            measuredPct_nxt = scaled[15:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            measuredPct_r <= `DPS_RST_PCT;
        end
        else
        begin
            measuredPct_r <= measuredPct_nxt;
        end
    end

    assign measuredPct = measuredPct_r;

endmodule

`default_nettype wire

// File: logic/dps_pkg.sv
// dps_pkg.sv: types of the dancer speed trim block
// assumes: dps_cfg.svh on the include path
`include "dps_cfg.svh"

package dps_pkg;

    // source feeding the main speed command
    typedef enum logic [2:0] {
        DPS_SRC_TERM2,
        DPS_SRC_TERM4,
        DPS_SRC_MULTI,
        DPS_SRC_PANEL,
        DPS_SRC_NETWORK
    } dps_src_t;

    // dancer control state
    typedef enum logic {
        DPS_ST_NORMAL,
        DPS_ST_DANCER
    } dps_state_t;

endpackage

// File: testbench/dps_dancer_trim_bench.sv
// dps_dancer_trim_bench.sv: self-checking bench of the trim block
// assumes: design, checker and roller model compiled first
`timescale 1ns/1ps
`default_nettype none
module dps_dancer_trim_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic running = 1'b0;
    logic revDir = 1'b0;
    logic [4:0] pins = 5'h00;
    logic [1:0] rng = 2'h0;
    logic [7:0] act = 8'h00, fs4 = 8'h00, fs0 = 8'h00;
    logic [7:0] selA = 8'h00, selB = 8'h00, selC = 8'h00;
    logic [15:0] sp = 16'h0000, upLim = 16'h270f, loLim = 16'h270f;
    logic [15:0] therm = 16'h270f, gain = 16'h1770, bias = 16'h0000;
    logic [15:0] msc = 16'h03e8, ofreq = 16'h0000, pos = 16'h0000;
    logic signed [11:0] corr = 12'sh000;
    dps_pkg::dps_src_t src = dps_pkg::DPS_SRC_PANEL;
    logic [11:0] adc;
    logic [15:0] spd, spPct, spFreq, mPct;
    logic revAct, rej;
    logic [2:0] term;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    dps_roller_model i_dps_roller_model
    (.clk(clk), .rangeSel(rng), .posPct(pos), .adcCode(adc));

    dps_dancer_trim i_dps_dancer_trim
    (
        .clk(clk), .rst_b(rst_b), .actionSelectParam(act),
        .inputFunctionSelect0(fs0), .inputFunctionSelect1(8'h00),
        .inputFunctionSelect2(8'h00), .inputFunctionSelect3(8'h00),
        .inputFunctionSelect4(fs4), .inputTerminals(pins),
        .outputFunctionSelectA(selA), .outputFunctionSelectB(selB),
        .outputFunctionSelectC(selC), .setPointParam(sp),
        .upperLimitParam(upLim), .lowerLimitParam(loLim),
        .thermistorLevelParam(therm), .inputRangeSelect(rng),
        .measuredAdc(adc), .analogGainFrequency(gain),
        .analogBiasFrequency(bias), .mainSpeedCmd(msc),
        .mainSpeedSource(src), .outputFrequency(ofreq),
        .running(running), .reverseDir(revDir), .pidCorrection(corr),
        .speedCommand(spd), .setPointPct(spPct), .setPointFreq(spFreq),
        .measuredValuePct(mPct), .pidReverseAction(revAct),
        .mainSpeedRejected(rej), .outputTerminals(term)
    );

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmpBit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    function automatic logic [15:0] expPct(input logic [1:0] r,
                                           input logic [11:0] c);
        int off;
        int span;
        off  = (r == 2'h0) ? 32'h333 : 32'h0;
        span = (r == 2'h0) ? 32'hccc : ((r == 2'h1) ? 32'h7ff : 32'hfff);
        return 16'((int'(c) - off) * 32'h3e8 / span);
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_range;
        for (int r = 0; r < 3; r++)
        begin
            for (int p = 0; p <= 1000; p += 500)
            begin
                rng <= 2'(r);
                pos <= 16'(p);
                settle;
                cmp16(mPct, expPct(rng, adc));
            end
        end
        rng <= 2'h0;
        $display("test range done");
    endtask

    task automatic t_setpoint;
        sp <= 16'h270f;
        settle;
        cmp16(spPct, 16'h01f4);
        cmp16(spFreq, 16'h0bb8);
        sp <= 16'h012c;
        bias <= 16'h03e8;
        settle;
        cmp16(spPct, 16'h012c);
        cmp16(spFreq, 16'h09c4);
        bias <= 16'h0000;
        $display("test setpoint done");
    endtask

    task automatic t_flags;
        act <= 8'h29;
        selA <= 8'h10;
        selB <= 8'h0f;
        selC <= 8'h2f;
        upLim <= 16'h0320;
        pos <= 16'h0384;
        running <= 1'b1;
        settle;
        cmpBit(term[0], 1'b1);
        cmpBit(term[1], 1'b1);
        cmpBit(term[2], 1'b1);
        revDir <= 1'b1;
        settle;
        cmpBit(term[0], 1'b0);
        revDir <= 1'b0;
        selA <= 8'h74;
        selB <= 8'h73;
        selC <= 8'h93;
        settle;
        cmp16({13'h0, term}, 16'h0000);
        selA <= 8'h10;
        selB <= 8'h0e;
        selC <= 8'h2f;
        loLim <= 16'h00c8;
        pos <= 16'h0064;
        settle;
        cmpBit(term[1], 1'b1);
        selB <= 8'h0f;
        upLim <= 16'h270f;
        pos <= 16'h0384;
        settle;
        cmpBit(term[1], 1'b0);
        for (int a = 40; a < 44; a++)
        begin
            act <= 8'(a);
            settle;
            cmpBit(term[2], 1'b1);
            cmpBit(revAct, ~act[0]);
        end
        running <= 1'b0;
        settle;
        cmpBit(term[0], 1'b0);
        cmpBit(term[2], 1'b1);
        running <= 1'b1;
        act <= 8'h00;
        settle;
        cmpBit(term[2], 1'b0);
        act <= 8'h2c;
        settle;
        cmpBit(term[2], 1'b0);
        $display("test flags done");
    endtask

    task automatic t_enable;
        act <= 8'h29;
        fs4 <= 8'h0e;
        ofreq <= 16'h0bb8;
        settle;
        cmpBit(term[2], 1'b0);
        cmp16(spd, 16'h03e8);
        pins <= 5'h10;
        settle;
        cmpBit(term[2], 1'b1);
        cmp16(spd, 16'h0bb8);
        ofreq <= 16'h0fa0;
        corr <= 12'sh064;
        settle;
        cmp16(spd, 16'h0e10);
        act <= 8'h2b;
        settle;
        cmp16(spd, 16'h0ce4);
        pins <= 5'h00;
        settle;
        cmp16(spd, 16'h03e8);
        cmpBit(term[2], 1'b0);
        corr <= 12'sh000;
        fs4 <= 8'h00;
        fs0 <= 8'h0e;
        settle;
        cmpBit(term[2], 1'b0);
        pins <= 5'h01;
        settle;
        cmpBit(term[2], 1'b1);
        fs0 <= 8'h00;
        pins <= 5'h00;
        act <= 8'h00;
        $display("test enable done");
    endtask

    task automatic t_source;
        src <= dps_pkg::DPS_SRC_TERM4;
        settle;
        cmpBit(rej, 1'b1);
        cmp16(spd, 16'h0000);
        src <= dps_pkg::DPS_SRC_TERM2;
        settle;
        cmpBit(rej, 1'b0);
        cmp16(spd, 16'h03e8);
        therm <= 16'h0064;
        settle;
        cmpBit(rej, 1'b1);
        cmp16(spd, 16'h0000);
        src <= dps_pkg::DPS_SRC_MULTI;
        settle;
        cmpBit(rej, 1'b0);
        $display("test source done");
    endtask

    task automatic test_done;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            fail_count++;
            $display("MISMATCH %0t: run did not finish", $time);
            test_done;
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        settle;
        t_range;
        t_setpoint;
        t_flags;
        t_enable;
        t_source;
        test_done;
    end
endmodule

bind dps_dancer_trim dps_dancer_trim_chk i_dps_dancer_trim_chk
(
    .clk, .rst_b, .actionSelectParam, .outputFunctionSelectA,
    .outputFunctionSelectB, .outputFunctionSelectC, .setPointParam,
    .upperLimitParam, .thermistorLevelParam, .mainSpeedCmd,
    .mainSpeedSource, .running, .reverseDir, .speedCommand,
    .setPointPct, .pidReverseAction, .mainSpeedRejected, .outputTerminals
);
`default_nettype wire

// File: testbench/dps_dancer_trim_chk.sv
// dps_dancer_trim_chk.sv: port assertions for the trim block
// assumes: bound to dps_dancer_trim, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module dps_dancer_trim_chk
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  actionSelectParam,
    input wire logic [7:0]  outputFunctionSelectA,
    input wire logic [7:0]  outputFunctionSelectB,
    input wire logic [7:0]  outputFunctionSelectC,
    input wire logic [15:0] setPointParam,
    input wire logic [15:0] upperLimitParam,
    input wire logic [15:0] thermistorLevelParam,
    input wire logic [15:0] mainSpeedCmd,
    input wire dps_pkg::dps_src_t mainSpeedSource,
    input wire logic        running,
    input wire logic        reverseDir,
    input wire logic [15:0] speedCommand,
    input wire logic [15:0] setPointPct,
    input wire logic        pidReverseAction,
    input wire logic        mainSpeedRejected,
    input wire logic [2:0]  outputTerminals
);
    // ----------------------------------------
    // cycles since reset release, saturating
    // ----------------------------------------
    logic [2:0] upCnt_r;
    logic [2:0] upCnt_nxt;
    logic       up;
    always_comb
    begin
        upCnt_nxt = (upCnt_r == 3'h7) ? upCnt_r : upCnt_r + 3'h1;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            upCnt_r <= 3'h0;
        else
            upCnt_r <= upCnt_nxt;
    end
    assign up = (upCnt_r >= 3'h4);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_REV_ACT: assert property (up && actionSelectParam == 8'h28
        |=> pidReverseAction) else $error("reverse action missing");
    AST_FWD_ACT: assert property (up && actionSelectParam == 8'h29
        |=> !pidReverseAction) else $error("forward action wrong");
    AST_SP_HALF: assert property (up && setPointParam == 16'h270f
        |=> setPointPct == 16'h01f4) else $error("half set point");
    AST_REJ_T4: assert property ((up && actionSelectParam == 8'h00 &&
        mainSpeedSource == dps_pkg::DPS_SRC_TERM4)[*3]
        |=> mainSpeedRejected && speedCommand == 16'h0000)
        else $error("terminal 4 speed taken");
    AST_REJ_T2: assert property (up && thermistorLevelParam != 16'h270f
        && mainSpeedSource == dps_pkg::DPS_SRC_TERM2 |=> mainSpeedRejected)
        else $error("terminal 2 taken with thermistor");
    AST_NORM: assert property ((up && actionSelectParam == 8'h00 &&
        mainSpeedSource == dps_pkg::DPS_SRC_PANEL && $stable(mainSpeedCmd))
        [*2] |=> speedCommand == $past(mainSpeedCmd))
        else $error("normal speed not passed");
    AST_DIR: assert property ((up && outputFunctionSelectA == 8'h10 &&
        running && !reverseDir)[*3] |=> outputTerminals[0])
        else $error("direction flag off");
    AST_INV: assert property ((up && outputFunctionSelectA == 8'h74 &&
        running && !reverseDir)[*3] |=> !outputTerminals[0])
        else $error("inverted direction flag on");
    AST_LIM: assert property ((up && upperLimitParam == 16'h270f &&
        outputFunctionSelectB == 8'h0f)[*3] |=> !outputTerminals[1])
        else $error("upper flag with limit off");
    AST_NOPID: assert property ((up && actionSelectParam == 8'h00 &&
        outputFunctionSelectC == 8'h2f)[*4] |=> !outputTerminals[2])
        else $error("pid flag in normal run");
    cover property (up && outputTerminals[2]);
    cover property (up && mainSpeedRejected);
    cover property (up && pidReverseAction);
endmodule
`default_nettype wire

// File: testbench/dps_roller_model.sv
// dps_roller_model.sv: roller position detector model
// assumes: position in tenths of a percent, 0 to 1000
`timescale 1ns/1ps
`default_nettype none
module dps_roller_model
(
    input  wire logic        clk,
    input  wire logic [1:0]  rangeSel,
    input  wire logic [15:0] posPct,
    output var  logic [11:0] adcCode
);
    int code;
    always_comb
    begin
        case (rangeSel)
            2'h0:    code = 32'h333 + int'(posPct) * 32'hccc / 32'h3e8;
            2'h1:    code = int'(posPct) * 32'h7ff / 32'h3e8;
            default: code = int'(posPct) * 32'hfff / 32'h3e8;
        endcase
    end
    // sampled front end: one code per clock
    always_ff @(posedge clk)
    begin
        adcCode <= code[11:0];
    end
endmodule
`default_nettype wire
